//--- design/frm_fifo_retransmit.sv
// fifo storage with retransmit-from-mark read control, single read clock
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
module frm_fifo_retransmit
    import frm_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_fall_through_mode,
    input  wire logic        i_single_rate,
    input  wire logic [1:0]  i_bus_width,
    input  wire logic        i_write_en_n,
    input  wire logic [39:0] i_write_data_in,
    input  wire logic        i_read_en_n,
    input  wire logic        i_mark,
    input  wire logic        i_retransmit_request_n,
    output logic      [39:0] o_read_data,
    output logic             o_empty_flag_n,
    output logic             o_output_ready_n,
    output logic             o_full_n,
    output logic             o_write_refused,
    output logic             o_mark_active,
    output logic             o_retx_setup
);

    // ------------------------------------------------------------------
    // configuration, caught while reset is held
    // ------------------------------------------------------------------
    logic          fall_thru_r;
    logic          dbl_r;
    logic [1:0]    width_r;

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            fall_thru_r <= i_fall_through_mode & i_single_rate;
            dbl_r   <= ~i_single_rate;
            width_r <= i_bus_width;
        end
    end

    // ------------------------------------------------------------------
    // storage and pointers
    // ------------------------------------------------------------------
    logic [39:0]   mem [FRM_DEPTH];
    logic [13:0]   wr_ptr_r;
    logic [13:0]   rd_ptr_r;
    logic [13:0]   mark_ptr_r;
    logic [13:0]   out_addr_r;
    logic [14:0]   cnt_r;
    logic [14:0]   cnt_nxt;
    logic [39:0]   out_r;
    logic          mark_r;
    logic          empty_n_r;
    logic          setup_r;
    logic          or_n_r;
    logic          full_n_r;
    logic          refused_r;
    frm_rd_state_t state_r;

    logic [39:0]   wdata;
    logic          wr_req;
    logic          wr_block;
    logic          wr_fire;
    logic          retx_fire;
    logic          rd_fire;
    logic          mark_set;
    logic [13:0]   mark_loc;

    always_comb
    begin
        if (width_r == FRM_WID_20)
            wdata = i_write_data_in & FRM_MASK_20;
        else if (width_r == FRM_WID_10)
            wdata = i_write_data_in & FRM_MASK_10;
        else
            wdata = i_write_data_in & FRM_MASK_40;
    end

    // pair locations: in double rate the low address bit picks the half
    assign mark_loc = dbl_r ? (out_addr_r & FRM_PAIR_ALIGN) : out_addr_r;

    assign wr_req   = ~i_write_en_n;
    // retained data between mark and writer must not be overwritten
    assign wr_block = mark_r && (wr_ptr_r == mark_ptr_r);
    assign wr_fire  = wr_req && (cnt_r != FRM_CNT_FULL) && !wr_block;

    assign retx_fire = !i_retransmit_request_n && mark_r && (state_r == FRM_RD_IDLE);

    always_comb
    begin
        rd_fire = 1'b0;
        if (state_r == FRM_RD_SETUP)
            rd_fire = fall_thru_r && (cnt_r != FRM_CNT_RST);
        else if (!retx_fire && cnt_r != FRM_CNT_RST)
        begin
            if (fall_thru_r)
                rd_fire = or_n_r || !i_read_en_n;
            else
                rd_fire = empty_n_r && !i_read_en_n;
        end
    end

    assign mark_set = !mark_r && i_mark && (fall_thru_r ? !or_n_r : empty_n_r);

    always_comb
    begin
        if (retx_fire)
            cnt_nxt = {1'b0, wr_ptr_r - mark_ptr_r} + {14'h0000, wr_fire};
        else
            cnt_nxt = cnt_r + {14'h0000, wr_fire} - {14'h0000, rd_fire};
    end

    // ------------------------------------------------------------------
    // write side
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (wr_fire)
            mem[wr_ptr_r] <= wdata;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            wr_ptr_r  <= FRM_PTR_RST;
            refused_r <= 1'b0;
            full_n_r  <= 1'b1;
        end
        else
        begin
            if (wr_fire)
                wr_ptr_r <= wr_ptr_r + 14'h0001;
            refused_r <= wr_req && !wr_fire;
            full_n_r  <= (cnt_nxt != FRM_CNT_FULL);
        end
    end

    // ------------------------------------------------------------------
    // mark register
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            mark_r     <= 1'b0;
            mark_ptr_r <= FRM_PTR_RST;
        end
        else if (!i_mark)
            mark_r <= 1'b0;
        else if (mark_set)
        begin
            mark_r     <= 1'b1;
            mark_ptr_r <= mark_loc;
        end
    end

    // ------------------------------------------------------------------
    // read side, output register and flags
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            rd_ptr_r   <= FRM_PTR_RST;
            out_addr_r <= FRM_PTR_RST;
            out_r      <= FRM_OUT_RST;
            cnt_r      <= FRM_CNT_RST;
            empty_n_r  <= 1'b0;
            or_n_r     <= 1'b1;
            state_r    <= FRM_RD_IDLE;
            setup_r    <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            if (retx_fire)
            begin
                // setup: flag drops for one cycle, reads are held off
                rd_ptr_r  <= mark_ptr_r;
                state_r   <= FRM_RD_SETUP;
                setup_r   <= 1'b1;
                empty_n_r <= 1'b0;
                or_n_r    <= 1'b1;
            end
            else
            begin
                state_r <= FRM_RD_IDLE;
                setup_r <= 1'b0;
                if (rd_fire)
                begin
                    out_r      <= mem[rd_ptr_r];
                    out_addr_r <= rd_ptr_r;
                    rd_ptr_r   <= rd_ptr_r + 14'h0001;
                end
                empty_n_r <= (cnt_nxt != FRM_CNT_RST);
                if (rd_fire)
                    or_n_r <= 1'b0;
                else if (state_r == FRM_RD_SETUP || !i_read_en_n)
                    or_n_r <= 1'b1;
            end
        end
    end

    assign o_read_data      = out_r;
    assign o_empty_flag_n   = empty_n_r;
    assign o_output_ready_n = or_n_r;
    assign o_full_n         = full_n_r;
    assign o_write_refused  = refused_r;
    assign o_mark_active    = mark_r;
    assign o_retx_setup     = setup_r;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    a_mark_replace: assert property (mark_set && i_mark |=> mark_ptr_r == $past(mark_loc))
        else $error("mark location not replaced");
    a_pair_align: assert property (dbl_r && mark_r |-> mark_ptr_r[0] == 1'b0)
        else $error("double rate mark not on pair boundary");
    a_mark_exit: assert property (!i_mark |=> !mark_r)
        else $error("mark low did not leave retransmit mode");
    a_retx_rewind: assert property (retx_fire |=> rd_ptr_r == $past(mark_ptr_r))
        else $error("read pointer not rewound to mark");
    a_empty_setup: assert property (!fall_thru_r && retx_fire |=> !empty_n_r
        ##1 (empty_n_r == (cnt_r != FRM_CNT_RST)))
        else $error("empty flag setup pulse wrong");
    a_or_setup: assert property (fall_thru_r && retx_fire |=> or_n_r ##1 !or_n_r)
        else $error("output ready setup pulse wrong");
    a_ft_load: assert property (fall_thru_r && retx_fire |=>
        ##1 out_addr_r == $past(mark_ptr_r, 2))
        else $error("marked word not loaded after setup");
    a_no_overrun: assert property (mark_r && wr_ptr_r == mark_ptr_r |=> $stable(wr_ptr_r))
        else $error("write passed the marked location");
    a_no_mark_retx: assert property (!mark_r && !i_retransmit_request_n |=>
        $stable(rd_ptr_r) || $past(rd_fire))
        else $error("retransmit acted without mark");
    a_setup_once: assert property (state_r == FRM_RD_SETUP |=> state_r == FRM_RD_IDLE)
        else $error("setup lasted more than one cycle");
    a_ft_single: assert property (fall_thru_r |-> !dbl_r)
        else $error("fall-through with double rate");

endmodule

//--- design/frm_pkg.sv
// constants and types for the retransmit-from-mark fifo read control
package frm_pkg;
    localparam int          FRM_DEPTH      = 16384;
    localparam int          FRM_PAIR_DEPTH = FRM_DEPTH / 2;
    localparam int          FRM_AW         = 14;
    localparam int          FRM_CW         = 15;
    localparam int          FRM_DW         = 40;
    localparam logic [1:0]  FRM_WID_40     = 2'h0;
    localparam logic [1:0]  FRM_WID_20     = 2'h1;
    localparam logic [1:0]  FRM_WID_10     = 2'h2;
    localparam logic [39:0] FRM_MASK_40    = 40'hff_ffff_ffff;
    localparam logic [39:0] FRM_MASK_20    = 40'h00_000f_ffff;
    localparam logic [39:0] FRM_MASK_10    = 40'h00_0000_03ff;
    localparam logic [39:0] FRM_OUT_RST    = 40'h00_0000_0000;
    localparam logic [13:0] FRM_PTR_RST    = 14'h0000;
    localparam logic [14:0] FRM_CNT_RST    = 15'h0000;
    localparam logic [14:0] FRM_CNT_FULL   = 15'h4000;
    localparam logic [13:0] FRM_PAIR_ALIGN = 14'h3ffe;
    // retransmit setup holds the flag for this many read cycles
    localparam int          FRM_SETUP_CYC  = 1;

    typedef enum logic [0:0] {
        FRM_RD_IDLE,
        FRM_RD_SETUP
    } frm_rd_state_t;
endpackage

//--- verification/frm_writer.sv
// write-side partner model: streams consecutive words into the fifo
module frm_writer (
    input  wire logic        i_clk,
    input  wire logic        i_go,
    input  wire logic [15:0] i_num,
    input  wire logic [39:0] i_base,
    output logic             o_write_en_n,
    output logic      [39:0] o_write_data_in,
    output logic             o_busy
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] left;
    logic        go_s;

    initial
    begin
        o_write_en_n = 1'b1;
        o_write_data_in = 40'h0;
        o_busy = 1'b0;
        left = 16'h0;
    end

    // go sampled on the edge, outputs move 1ns later like the bench
    always @(posedge i_clk)
    begin
        go_s = i_go;
        #1;
        if (go_s && !o_busy)
        begin
            left = i_num;
            o_busy = 1'b1;
            o_write_data_in = i_base - 40'h1;
        end
        if (left != 16'h0)
        begin
            o_write_en_n = 1'b0;
            o_write_data_in = o_write_data_in + 40'h1;
            left = left - 16'h1;
        end
        else
        begin
            // idle data keeps toggling so a stale word never looks valid
            o_write_en_n = 1'b1;
            o_write_data_in = ~o_write_data_in;
            o_busy = 1'b0;
        end
    end
endmodule

//--- verification/fifo_retransmit_from_mark_tb_top.sv
// self-checking bench for the retransmit-from-mark fifo
module fifo_retransmit_from_mark_tb_top
    import frm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        i_clk, i_rst_b, ff, sr, fw, ren_n, mark, retx_n, go, wen_n, busy;
    logic [1:0]  bw;
    logic [15:0] num;
    logic [39:0] base, wd, q;
    logic        empty_n, ready_n, full_n, refd, mact, setup;
    int          num_errors, total_checks, nref;

    frm_fifo_retransmit u_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_fall_through_mode(ff),
        .i_single_rate(sr), .i_bus_width(bw), .i_write_en_n(wen_n), .i_write_data_in(wd),
        .i_read_en_n(ren_n), .i_mark(mark), .i_retransmit_request_n(retx_n),
        .o_read_data(q), .o_empty_flag_n(empty_n), .o_output_ready_n(ready_n),
        .o_full_n(full_n), .o_write_refused(refd), .o_mark_active(mact),
        .o_retx_setup(setup));
    frm_writer u_wr (.i_clk(i_clk), .i_go(go), .i_num(num), .i_base(base),
        .o_write_en_n(wen_n), .o_write_data_in(wd), .o_busy(busy));

    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // counted mid-cycle, where the one-cycle pulse has settled
    always @(negedge i_clk) if (refd === 1'b1) nref++;

    // ----------------------------------------------------------------
    // access tasks
    // ----------------------------------------------------------------
    task automatic tick(input int n = 1);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic chk(input string s, input logic [39:0] seen, input logic [39:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task automatic cfg(input logic f, input logic r, input logic [1:0] w);
        {ff, sr, bw, i_rst_b, mark} = {f, r, w, 2'b00};
        fw = f & r;
        tick(12);
        i_rst_b = 1'b1;
    endtask
    task automatic wr(input logic [15:0] n, input logic [39:0] b);
        {go, num, base} = {1'b1, n, b};
        tick();
        go = 1'b0;
        tick();
        repeat (20000) if (busy) tick();
        tick(3);
    endtask
    // read enable is left high after each burst, as a retransmit needs
    task automatic rd(input int n);
        ren_n = 1'b0;
        tick(n);
        ren_n = 1'b1;
        tick();
    endtask
    task automatic retx(input logic [39:0] first);
        retx_n = 1'b0;
        tick();
        retx_n = 1'b1;
        chk("setup", setup, 40'h1);
        chk("flag", fw ? ready_n : !empty_n, 40'h1);
        tick();
        chk("setup", setup, 40'h0);
        chk("flag", fw ? ready_n : !empty_n, 40'h0);
        if (fw) chk("q", q, first);
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial
    begin
        {ren_n, retx_n, go, num, base} = {1'b1, 1'b1, 1'b0, 16'h0, 40'h0};
        num_errors = 0;
        total_checks = 0;
        nref = 0;
        cfg(1'b0, 1'b1, FRM_WID_40);
        wr(16'd40, 40'h100);
        rd(3);
        chk("q", q, 40'h102);
        mark = 1'b1;
        tick(2);
        chk("mark_active", mact, 40'h1);
        rd(2);
        repeat (2)
        begin
            retx('0);
            rd(1);
            chk("q", q, 40'h102);
            rd(1);
            chk("q", q, 40'h103);
        end
        mark = 1'b0;
        tick(2);
        chk("mark_active", mact, 40'h0);
        retx_n = 1'b0;
        tick();
        retx_n = 1'b1;
        chk("setup", setup, 40'h0);
        tick();
        rd(1);
        chk("q", q, 40'h104);
        mark = 1'b1;
        tick(2);
        rd(2);
        retx('0);
        rd(1);
        chk("q", q, 40'h104);
        // writer wraps round onto the mark: the last two words must bounce
        nref = 0;
        wr(16'd16350, 40'h1000);
        chk("refused", nref, 40'h2);
        rd(1);
        chk("q", q, 40'h105);
        // with the mark released the writer fills the last two free slots
        mark = 1'b0;
        tick(2);
        nref = 0;
        wr(16'd3, 40'h5000);
        chk("full", full_n, 40'h0);
        chk("refused", nref, 40'h1);
        rd(1);
        chk("q", q, 40'h106);
        chk("full", full_n, 40'h1);
        cfg(1'b1, 1'b1, FRM_WID_20);
        wr(16'd40, 40'h12_3450_0a00);
        chk("ready", ready_n, 40'h0);
        chk("q", q, 40'h00a00);
        rd(1);
        chk("q", q, 40'h00a01);
        mark = 1'b1;
        tick(2);
        chk("mark_active", mact, 40'h1);
        rd(2);
        retx(40'h00a01);
        rd(1);
        chk("q", q, 40'h00a02);
        // fall-through asked at double rate must stay standard
        cfg(1'b1, 1'b0, FRM_WID_40);
        wr(16'd40, 40'h200);
        chk("q", q, 40'h0);
        rd(4);
        mark = 1'b1;
        tick(2);
        rd(1);
        retx('0);
        rd(1);
        chk("q", q, 40'h202);
        rd(1);
        chk("q", q, 40'h203);
        test_done();
    end

    initial
    begin
        #400000;
        num_errors++;
        test_done();
    end
endmodule
